// ==== rtl/spa_param_access.sv ====
// parameter access interpreter: mnemonic decode, command and state words, tag conversion
`timescale 1ns/100ps
`include "spa_defines.svh"
// Behaviour
// - main, keypad and option version words read only, full sixteen bits
// - keypad version reads zero when no keypad is attached
// - a write to last error word forces it to 00c0 unless a hardware error comes in the same cycle
// - command 7777 acknowledges failed restore, loads default code and config, no save
// - command 0101 restores the saved configuration from non-volatile memory
// - command word write only; 0111 defaults, 5555 enter, 4444 leave config mode
// - read-only state word reports the six major states
// - writing zero to save command clears an earlier save error
// - writing one to save command starts saving the configuration
// - save progress reads 0 idle, 1 saving, 2 failed
// - parameters are addressed by a two-character mnemonic derived from tag
// - tags below 936: quotient and remainder of (tag+360)/36
// - low range index above 9 is lowercase letter, otherwise digit
// - tags from 936: 'a' plus quotient, 'A' plus remainder of (tag-936)/26
// - mnemonics hold only digits, uppercase and lowercase letters
// - legacy parameter-number mnemonics are accepted as well
// - port mode tag 130 selects ascii, tag 198 baud, addresses must match
// - half duplex multipoint, one acknowledgement per message
// - decimal values must carry the decimal point
// - booleans are 00 or 01, single digit forms accepted
module spa_param_access #(
	parameter int AW = 11,
	parameter logic [15:0] IDENTITY = 16'h1234, // arbitrary value
	parameter logic [15:0] ASCII_MODE = 16'h0001,
	parameter logic [15:0] BAUD_RESET = 16'h0000
) (
	input logic clk_i,
	input logic rst_n_i,
	input logic req_valid_i,
	input spa_pkg::spa_req_t req_i,
	output logic rsp_valid_o,
	output spa_pkg::spa_rsp_t rsp_o,
	input logic [7:0] cluster_address_i,
	input logic [7:0] station_address_i,
	input logic [15:0] main_ver_i,
	input logic [15:0] keypad_ver_i,
	input logic keypad_present_i,
	input logic [15:0] option_ver_i,
	input logic err_valid_i,
	input logic [15:0] err_code_i,
	input logic restore_done_i,
	input logic restore_ok_i,
	input logic code_ok_i,
	input logic save_done_i,
	input logic save_ok_i,
	output logic nv_restore_o,
	output logic nv_save_o,
	output logic load_defaults_o,
	output logic load_code_o,
	output logic [15:0] major_state_o,
	output logic [15:0] save_progress_o,
	output logic [15:0] last_error_o,
	output logic ascii_mode_o,
	output logic [15:0] baud_sel_o,
	input logic tag_valid_i,
	input logic [10:0] tag_i,
	output logic mnem_valid_o,
	output logic [15:0] mnem_o,
	output logic mnem_nak_o
);
	if (AW < `SPA_MIN_AW) begin : g_aw_check
		$error("address width too small for tag and legacy space");
	end

	function automatic logic [6:0] spa_b36(input logic [7:0] c);
		logic [6:0] r;
		r = 7'h00;
		if (c >= `SPA_CH_DIGIT && c <= `SPA_CH_NINE) begin
			r = {1'b1, 6'(c - `SPA_CH_DIGIT)};
		end else if (c >= `SPA_CH_LOWER && c <= `SPA_CH_LOWER_Z) begin
			r = {1'b1, 6'(c - `SPA_CH_LOWER) + `SPA_LETTER_BASE};
		end
		return r;
	endfunction : spa_b36

	function automatic logic [7:0] spa_b36_char(input logic [5:0] d);
		logic [7:0] r;
		r = (d > `SPA_DIGIT_MAX) ? `SPA_CH_LOWER + 8'(d - `SPA_LETTER_BASE)
			: `SPA_CH_DIGIT + 8'(d);
		return r;
	endfunction : spa_b36_char

	function automatic logic spa_char_ok(input logic [7:0] c);
		return (c >= `SPA_CH_DIGIT && c <= `SPA_CH_NINE)
			|| (c >= `SPA_CH_UPPER && c <= `SPA_CH_UPPER_Z)
			|| (c >= `SPA_CH_LOWER && c <= `SPA_CH_LOWER_Z);
	endfunction : spa_char_ok

	// decode of the incoming mnemonic
	logic [7:0] c1, c2;
	logic [6:0] d1, d2;
	logic [10:0] low_val, high_val, tag_addr;
	logic low_ok, high_ok, legacy_ok, tag_ok, mem_hit;
	logic is_id, is_main, is_key, is_opt, is_err, is_cmd, is_state, is_save, is_prog;
	logic wr, addressed, take, val_ok, cmd_ok, save_ok, cmd_go, save_go, err_wr;
	logic mem_we, mem_re;
	logic [AW-1:0] mem_addr;
	logic [15:0] mem_rdata, key_ver, next_data;
	spa_pkg::spa_kind_t next_kind, s1_kind;
	logic s1_valid;
	logic [15:0] s1_data;
	spa_pkg::spa_major_t major, next_major;
	spa_pkg::spa_save_t save_st, next_save;
	logic next_defaults, next_code;

	assign c1 = req_i.mnem[15:8];
	assign c2 = req_i.mnem[7:0];
	assign d1 = spa_b36(c1);
	assign d2 = spa_b36(c2);
	assign low_ok = d1[6] & d2[6];
	assign low_val = 11'(d1[5:0]) * `SPA_LOW_RADIX + 11'(d2[5:0]);
	assign high_ok = c1 >= `SPA_CH_LOWER && c1 <= `SPA_CH_LOWER_Z
		&& c2 >= `SPA_CH_UPPER && c2 <= `SPA_CH_UPPER_Z;
	assign high_val = `SPA_TAG_SPLIT + 11'(c1 - `SPA_CH_LOWER) * `SPA_HIGH_RADIX
		+ 11'(c2 - `SPA_CH_UPPER);
	// digit-led mnemonics below the tag offset map to no tag, so they are free for legacy numbers
	assign legacy_ok = low_ok && low_val < `SPA_TAG_OFFSET
		&& d1[5:4] == 2'h0 && d2[5:4] == 2'h0;
	assign tag_ok = (low_ok && low_val >= `SPA_TAG_OFFSET) || high_ok;
	assign tag_addr = high_ok ? high_val : low_val - `SPA_TAG_OFFSET;
	assign mem_hit = tag_ok || legacy_ok;
	assign mem_addr = legacy_ok ? AW'(`SPA_LEGACY_BASE + 11'({d1[3:0], d2[3:0]}))
		: AW'(tag_addr);

	assign is_id = req_i.mnem == `SPA_MN_IDENTITY;
	assign is_main = req_i.mnem == `SPA_MN_MAIN_VER;
	assign is_key = req_i.mnem == `SPA_MN_KEYPAD_VER;
	assign is_opt = req_i.mnem == `SPA_MN_OPTION_VER;
	assign is_err = req_i.mnem == `SPA_MN_LAST_ERR;
	assign is_cmd = req_i.mnem == `SPA_MN_COMMAND;
	assign is_state = req_i.mnem == `SPA_MN_STATE;
	assign is_save = req_i.mnem == `SPA_MN_SAVE_CMD;
	assign is_prog = req_i.mnem == `SPA_MN_SAVE_PROG;

	// a request for another station is not ours and gets no answer at all
	assign addressed = req_i.cluster == cluster_address_i
		&& req_i.station == station_address_i && ascii_mode_o;
	assign take = req_valid_i && addressed;
	assign wr = req_i.write;
	assign val_ok = (req_i.fmt == spa_pkg::SPA_FMT_DEC) ? req_i.point
		: (req_i.fmt == spa_pkg::SPA_FMT_BOOL) ? req_i.data <= `SPA_BOOL_TRUE
		: 1'b1;
	// commands are refused while the drive is still bringing up its configuration
	assign cmd_ok = major != spa_pkg::SPA_INIT && major != spa_pkg::SPA_RESTORING
		&& (req_i.data == `SPA_CMD_RESET || req_i.data == `SPA_CMD_RESTORE
		|| req_i.data == `SPA_CMD_DEFAULTS || req_i.data == `SPA_CMD_CFG_EXIT
		|| req_i.data == `SPA_CMD_CFG_ENTER);
	assign save_ok = req_i.data == `SPA_SAVE_CLEAR
		|| (req_i.data == `SPA_SAVE_START && save_st != spa_pkg::SPA_SV_SAVING);
	assign cmd_go = take && wr && is_cmd && cmd_ok;
	assign save_go = take && wr && is_save && save_ok;
	assign err_wr = take && wr && is_err;
	assign mem_we = take && wr && mem_hit && val_ok;
	assign mem_re = take && !wr && mem_hit;

	assign key_ver = keypad_present_i ? keypad_ver_i : 16'h0000;
	assign next_data = is_id ? IDENTITY : is_main ? main_ver_i : is_key ? key_ver
		: is_opt ? option_ver_i : is_err ? last_error_o
		: is_state ? major_state_o : save_progress_o;
	// write-only words answer a read with a refusal, read-only words refuse writes
	assign next_kind = (is_id || is_main || is_key || is_opt || is_state || is_prog)
		? (wr ? spa_pkg::SPA_K_NAK : spa_pkg::SPA_K_DATA)
		: is_err ? (wr ? spa_pkg::SPA_K_ACK : spa_pkg::SPA_K_DATA)
		: is_cmd ? (cmd_go ? spa_pkg::SPA_K_ACK : spa_pkg::SPA_K_NAK)
		: is_save ? (save_go ? spa_pkg::SPA_K_ACK : spa_pkg::SPA_K_NAK)
		: mem_hit ? (!wr ? spa_pkg::SPA_K_MEM
		: val_ok ? spa_pkg::SPA_K_ACK : spa_pkg::SPA_K_NAK)
		: spa_pkg::SPA_K_NAK;

	spa_param_mem #(
		.DW(16),
		.AW(AW)
	) u_mem (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.we_i(mem_we),
		.re_i(mem_re),
		.addr_i(mem_addr),
		.wdata_i(req_i.data),
		.rdata_o(mem_rdata)
	);

	// two-stage answer: exactly one reply for each message taken
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_valid <= 1'b0;
			s1_kind <= spa_pkg::SPA_K_NAK;
			s1_data <= 16'h0000;
			rsp_valid_o <= 1'b0;
			rsp_o <= '0;
		end else begin
			s1_valid <= take;
			s1_kind <= next_kind;
			s1_data <= next_data;
			rsp_valid_o <= s1_valid;
			rsp_o.nak <= s1_valid && s1_kind == spa_pkg::SPA_K_NAK;
			rsp_o.data <= !s1_valid ? 16'h0000
				: s1_kind == spa_pkg::SPA_K_MEM ? mem_rdata
				: s1_kind == spa_pkg::SPA_K_DATA ? s1_data : 16'h0000;
		end
	end

	// a hardware error in the same cycle as a software write wins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_error_o <= `SPA_ERR_RESET;
		end else if (err_valid_i) begin
			last_error_o <= err_code_i;
		end else if (err_wr) begin
			last_error_o <= `SPA_ERR_FORCED;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ascii_mode_o <= 1'b1;
			baud_sel_o <= BAUD_RESET;
		end else if (mem_we && tag_ok && tag_addr == `SPA_TAG_PORT_MODE) begin
			ascii_mode_o <= req_i.data == ASCII_MODE;
		end else if (mem_we && tag_ok && tag_addr == `SPA_TAG_BAUD) begin
			baud_sel_o <= req_i.data;
		end
	end

	always_comb begin
		next_major = major;
		next_defaults = 1'b0;
		next_code = 1'b0;
		case (major)
			spa_pkg::SPA_INIT: begin
				next_major = spa_pkg::SPA_RESTORING;
			end
			spa_pkg::SPA_RESTORING: begin
				if (restore_done_i) begin
					next_major = restore_ok_i ? spa_pkg::SPA_NORMAL
						: code_ok_i ? spa_pkg::SPA_BAD_CFG : spa_pkg::SPA_BAD_ALL;
				end
			end
			spa_pkg::SPA_BAD_ALL, spa_pkg::SPA_BAD_CFG,
			spa_pkg::SPA_RECONFIG, spa_pkg::SPA_NORMAL: begin
				// reset command loads defaults but never saves them
				if (cmd_go && req_i.data == `SPA_CMD_RESET) begin
					next_major = spa_pkg::SPA_NORMAL;
					next_defaults = 1'b1;
					next_code = 1'b1;
				end else if (cmd_go && req_i.data == `SPA_CMD_DEFAULTS) begin
					next_major = spa_pkg::SPA_NORMAL;
					next_defaults = 1'b1;
				end else if (cmd_go && req_i.data == `SPA_CMD_RESTORE) begin
					next_major = spa_pkg::SPA_RESTORING;
				end else if (cmd_go && req_i.data == `SPA_CMD_CFG_ENTER) begin
					next_major = spa_pkg::SPA_RECONFIG;
				end else if (cmd_go && req_i.data == `SPA_CMD_CFG_EXIT
					&& major == spa_pkg::SPA_RECONFIG) begin
					next_major = spa_pkg::SPA_NORMAL;
				end
			end
			default: begin
				next_major = spa_pkg::SPA_INIT;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			major <= spa_pkg::SPA_INIT;
			major_state_o <= `SPA_ST_INIT;
			nv_restore_o <= 1'b0;
			load_defaults_o <= 1'b0;
			load_code_o <= 1'b0;
		end else begin
			major <= next_major;
			major_state_o <= next_major == spa_pkg::SPA_BAD_ALL ? `SPA_ST_BAD_ALL
				: next_major == spa_pkg::SPA_BAD_CFG ? `SPA_ST_BAD_CFG
				: next_major == spa_pkg::SPA_RESTORING ? `SPA_ST_RESTORING
				: next_major == spa_pkg::SPA_RECONFIG ? `SPA_ST_RECONFIG
				: next_major == spa_pkg::SPA_NORMAL ? `SPA_ST_NORMAL : `SPA_ST_INIT;
			nv_restore_o <= next_major == spa_pkg::SPA_RESTORING;
			load_defaults_o <= next_defaults;
			load_code_o <= next_code;
		end
	end

	always_comb begin
		next_save = save_st;
		case (save_st)
			spa_pkg::SPA_SV_IDLE: begin
				if (save_go && req_i.data == `SPA_SAVE_START) begin
					next_save = spa_pkg::SPA_SV_SAVING;
				end
			end
			spa_pkg::SPA_SV_SAVING: begin
				if (save_done_i) begin
					next_save = save_ok_i ? spa_pkg::SPA_SV_IDLE : spa_pkg::SPA_SV_FAILED;
				end
			end
			spa_pkg::SPA_SV_FAILED: begin
				if (save_go && req_i.data == `SPA_SAVE_START) begin
					next_save = spa_pkg::SPA_SV_SAVING;
				end else if (save_go) begin
					next_save = spa_pkg::SPA_SV_IDLE;
				end
			end
			default: begin
				next_save = spa_pkg::SPA_SV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			save_st <= spa_pkg::SPA_SV_IDLE;
			save_progress_o <= `SPA_PROG_IDLE;
			nv_save_o <= 1'b0;
		end else begin
			save_st <= next_save;
			save_progress_o <= next_save == spa_pkg::SPA_SV_SAVING ? `SPA_PROG_SAVING
				: next_save == spa_pkg::SPA_SV_FAILED ? `SPA_PROG_FAILED : `SPA_PROG_IDLE;
			nv_save_o <= next_save == spa_pkg::SPA_SV_SAVING;
		end
	end

	// tag to mnemonic converter for the front end's replies
	logic [10:0] conv_v;
	logic [5:0] conv_m, conv_n;
	logic [15:0] conv_mnem;
	assign conv_v = tag_i < `SPA_TAG_SPLIT ? tag_i + `SPA_TAG_OFFSET : tag_i - `SPA_TAG_SPLIT;
	assign conv_m = 6'(conv_v / (tag_i < `SPA_TAG_SPLIT ? `SPA_LOW_RADIX : `SPA_HIGH_RADIX));
	assign conv_n = 6'(conv_v % (tag_i < `SPA_TAG_SPLIT ? `SPA_LOW_RADIX : `SPA_HIGH_RADIX));
	assign conv_mnem = tag_i < `SPA_TAG_SPLIT
		? {spa_b36_char(conv_m), spa_b36_char(conv_n)}
		: {`SPA_CH_LOWER + 8'(conv_m), `SPA_CH_UPPER + 8'(conv_n)};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mnem_valid_o <= 1'b0;
			mnem_o <= 16'h0000;
			mnem_nak_o <= 1'b0;
		end else begin
			mnem_valid_o <= tag_valid_i;
			mnem_o <= tag_valid_i && tag_i < `SPA_TAG_LIMIT ? conv_mnem : 16'h0000;
			mnem_nak_o <= tag_valid_i && tag_i >= `SPA_TAG_LIMIT;
		end
	end

	a_one_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take |-> ##2 rsp_valid_o) else $error("taken message got no answer");
	a_keypad_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take && !wr && is_key && !keypad_present_i |-> ##2 rsp_o.data == 16'h0000)
		else $error("absent keypad version not zero");
	a_err_forced: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		err_wr && !err_valid_i |=> last_error_o == `SPA_ERR_FORCED)
		else $error("error word not forced");
	a_reset_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_go && req_i.data == `SPA_CMD_RESET |=> load_code_o && load_defaults_o
		&& major_state_o == `SPA_ST_NORMAL) else $error("reset command failed");
	a_restore_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_go && req_i.data == `SPA_CMD_RESTORE |=> nv_restore_o
		&& major_state_o == `SPA_ST_RESTORING) else $error("restore not started");
	a_cfg_enter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_go && req_i.data == `SPA_CMD_CFG_ENTER |=> major_state_o == `SPA_ST_RECONFIG)
		else $error("config mode not entered");
	a_state_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		major_state_o <= `SPA_ST_NORMAL) else $error("state code out of range");
	a_save_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		save_go && req_i.data == `SPA_SAVE_CLEAR && save_st == spa_pkg::SPA_SV_FAILED
		|=> save_progress_o == `SPA_PROG_IDLE) else $error("save error not cleared");
	a_save_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		save_go && req_i.data == `SPA_SAVE_START |=> nv_save_o
		&& save_progress_o == `SPA_PROG_SAVING) else $error("save not started");
	a_save_codes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		save_progress_o <= `SPA_PROG_FAILED) else $error("bad save progress code");
	a_mnem_chars: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tag_valid_i && tag_i < `SPA_TAG_LIMIT |=> spa_char_ok(mnem_o[15:8])
		&& spa_char_ok(mnem_o[7:0])) else $error("mnemonic has illegal character");
endmodule : spa_param_access

// ==== pkg/spa_defines.svh ====
// constants of the serial parameter access block
`ifndef SPA_DEFINES_SVH
`define SPA_DEFINES_SVH
`define SPA_CMD_RESET 16'h7777
`define SPA_CMD_RESTORE 16'h0101
`define SPA_CMD_DEFAULTS 16'h0111
`define SPA_CMD_CFG_EXIT 16'h4444
`define SPA_CMD_CFG_ENTER 16'h5555
`define SPA_SAVE_CLEAR 16'h0000
`define SPA_SAVE_START 16'h0001
`define SPA_PROG_IDLE 16'h0000
`define SPA_PROG_SAVING 16'h0001
`define SPA_PROG_FAILED 16'h0002
`define SPA_ERR_FORCED 16'h00c0
`define SPA_ERR_RESET 16'h0000
`define SPA_ST_INIT 16'h0000
`define SPA_ST_BAD_ALL 16'h0001
`define SPA_ST_BAD_CFG 16'h0002
`define SPA_ST_RESTORING 16'h0003
`define SPA_ST_RECONFIG 16'h0004
`define SPA_ST_NORMAL 16'h0005
`define SPA_MN_IDENTITY 16'h4949
`define SPA_MN_MAIN_VER 16'h5630
`define SPA_MN_KEYPAD_VER 16'h5631
`define SPA_MN_OPTION_VER 16'h5632
`define SPA_MN_LAST_ERR 16'h4545
`define SPA_MN_COMMAND 16'h2131
`define SPA_MN_STATE 16'h2132
`define SPA_MN_SAVE_CMD 16'h2133
`define SPA_MN_SAVE_PROG 16'h2134
`define SPA_TAG_SPLIT 11'h3a8
`define SPA_TAG_OFFSET 11'h168
`define SPA_TAG_LIMIT 11'h64c
`define SPA_LOW_RADIX 11'h024
`define SPA_HIGH_RADIX 11'h01a
`define SPA_LEGACY_BASE 11'h700
`define SPA_TAG_PORT_MODE 11'h082
`define SPA_TAG_BAUD 11'h0c6
`define SPA_CH_DIGIT 8'h30
`define SPA_CH_LOWER 8'h61
`define SPA_CH_UPPER 8'h41
`define SPA_CH_NINE 8'h39
`define SPA_CH_LOWER_Z 8'h7a
`define SPA_CH_UPPER_Z 8'h5a
`define SPA_DIGIT_MAX 6'h09
`define SPA_LETTER_BASE 6'h0a
`define SPA_BOOL_TRUE 16'h0001
`define SPA_MIN_AW 11
`endif

// ==== pkg/spa_pkg.sv ====
// types of the serial parameter access block
package spa_pkg;
	typedef enum logic [5:0] {
		SPA_INIT = 6'h01,
		SPA_BAD_ALL = 6'h02,
		SPA_BAD_CFG = 6'h04,
		SPA_RESTORING = 6'h08,
		SPA_RECONFIG = 6'h10,
		SPA_NORMAL = 6'h20
	} spa_major_t;
	typedef enum logic [2:0] {
		SPA_SV_IDLE = 3'h1,
		SPA_SV_SAVING = 3'h2,
		SPA_SV_FAILED = 3'h4
	} spa_save_t;
	typedef enum logic [1:0] {
		SPA_FMT_WORD = 2'h0,
		SPA_FMT_DEC = 2'h1,
		SPA_FMT_BOOL = 2'h2
	} spa_fmt_t;
	typedef enum logic [1:0] {
		SPA_K_DATA = 2'h0,
		SPA_K_MEM = 2'h1,
		SPA_K_ACK = 2'h2,
		SPA_K_NAK = 2'h3
	} spa_kind_t;
	typedef struct packed {
		logic write;
		logic [7:0] cluster;
		logic [7:0] station;
		logic [15:0] mnem;
		logic [15:0] data;
		spa_fmt_t fmt;
		logic point;
	} spa_req_t;
	typedef struct packed {
		logic nak;
		logic [15:0] data;
	} spa_rsp_t;
endpackage : spa_pkg

// ==== rtl/spa_param_mem.sv ====
// parameter value store with registered read data
`timescale 1ns/100ps
module spa_param_mem #(
	parameter int DW = 16,
	parameter int AW = 11
) (
	input logic clk_i,
	input logic rst_n_i,
	input logic we_i,
	input logic re_i,
	input logic [AW-1:0] addr_i,
	input logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (re_i) begin
			rdata_o <= mem[addr_i];
		end
	end
endmodule : spa_param_mem

// ==== tb/spa_supervisor.sv ====
// supervisor model: issues decoded messages and collects the single answer
`timescale 1ns/100ps
module spa_supervisor #(
	parameter logic [7:0] STATION = 8'h03
) (
	input wire logic clk_i,
	output spa_pkg::spa_req_t req_o,
	output logic req_valid_o,
	input wire logic rsp_valid_i,
	input wire spa_pkg::spa_rsp_t rsp_i
);
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end
	task automatic xfer(input logic w, input logic [15:0] mn, input logic [15:0] d,
		input spa_pkg::spa_fmt_t f, input logic pt, input logic [7:0] cl,
		output logic got, output int lat, output spa_pkg::spa_rsp_t r);
		got = 1'b0;
		lat = -1;
		r = '0;
		@(negedge clk_i);
		req_o = '{w, cl, STATION, mn, d, f, pt};
		req_valid_o = 1'b1;
		@(negedge clk_i);
		req_valid_o = 1'b0;
		// released fields must not keep looking valid
		req_o = ~req_o;
		// half duplex: the answer is awaited before any next message
		// lat 0 is the first falling edge after the release
		for (int k = 0; k < 4; k++) begin
			@(negedge clk_i);
			if (rsp_valid_i && !got) begin
				got = 1'b1;
				lat = k;
				r = rsp_i;
			end
		end
	endtask : xfer
endmodule : spa_supervisor

// ==== tb/spa_param_access_tb_top.sv ====
// self-checking bench of the serial parameter access block
`timescale 1ns/100ps
module spa_param_access_tb_top;
	logic clk, rst_n, rv, kp, ev, rd, rok, cok, sd, sok, tv;
	logic nvr, nvs, ldd, ldc, am, mnv, mnk, pt;
	logic [7:0] cl, st;
	logic [10:0] tg;
	logic [15:0] mv, kv, ov, ec, ms, sp, le, bs, mno;
	spa_pkg::spa_req_t rq;
	spa_pkg::spa_rsp_t rs;
	spa_pkg::spa_fmt_t fm;
	int mismatches, n_compared, n_ld, n_lc;
	logic rsv;
	spa_param_access dut (.clk_i(clk), .rst_n_i(rst_n), .req_valid_i(rv), .req_i(rq),
		.rsp_valid_o(rsv), .rsp_o(rs), .cluster_address_i(cl), .station_address_i(st),
		.main_ver_i(mv), .keypad_ver_i(kv), .keypad_present_i(kp), .option_ver_i(ov),
		.err_valid_i(ev), .err_code_i(ec), .restore_done_i(rd), .restore_ok_i(rok),
		.code_ok_i(cok), .save_done_i(sd), .save_ok_i(sok), .nv_restore_o(nvr),
		.nv_save_o(nvs), .load_defaults_o(ldd), .load_code_o(ldc), .major_state_o(ms),
		.save_progress_o(sp), .last_error_o(le), .ascii_mode_o(am), .baud_sel_o(bs),
		.tag_valid_i(tv), .tag_i(tg), .mnem_valid_o(mnv), .mnem_o(mno), .mnem_nak_o(mnk));
	spa_supervisor #(.STATION(8'h03)) sup (.clk_i(clk), .req_o(rq), .req_valid_o(rv),
		.rsp_valid_i(rsv), .rsp_i(rs));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// pulses are counted so that a missed or doubled one shows later
	always @(posedge clk) begin
		if (ldd === 1'b1) n_ld++;
		if (ldc === 1'b1) n_lc++;
	end
	task automatic wrap_up;
		if (mismatches == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	function automatic logic [15:0] mn_of(input int t);
		int q, m;
		if (t < 936) begin
			q = (t + 360) / 36;
			m = (t + 360) % 36;
			return {8'(q > 9 ? 87 + q : 48 + q), 8'(m > 9 ? 87 + m : 48 + m)};
		end
		q = (t - 936) / 26;
		m = (t - 936) % 26;
		return {8'(97 + q), 8'(65 + m)};
	endfunction : mn_of
	task automatic xf(input logic w, input logic [15:0] mn, input logic [15:0] d,
		input logic en, input logic [15:0] ed);
		logic got;
		int lat;
		spa_pkg::spa_rsp_t r;
		sup.xfer(w, mn, d, fm, pt, cl, got, lat, r);
		chk("answered", {15'h0, got}, 16'h0001);
		chk("latency", 16'(lat), 16'h0000);
		chk("nak", {15'h0, r.nak}, {15'h0, en});
		if (!w) chk("read data", r.data, ed);
	endtask : xf
	task automatic fin(input logic r, input logic s, input logic a, input logic b);
		@(negedge clk);
		rd = r;
		sd = s;
		rok = a;
		sok = a;
		cok = b;
		@(negedge clk);
		rd = 1'b0;
		sd = 1'b0;
	endtask : fin
	task automatic t_boot;
		chk("state", ms, 16'h0003);
		chk("restoring", {15'h0, nvr}, 16'h0001);
		chk("error", le, 16'h0000);
		chk("ascii", {15'h0, am}, 16'h0001);
		xf(1, 16'h2131, 16'h5555, 1, 0);
		fin(1, 0, 1, 1);
		chk("state", ms, 16'h0005);
	endtask : t_boot
	task automatic t_ident;
		xf(0, 16'h4949, 0, 0, 16'h1234);
		xf(0, 16'h5630, 0, 0, 16'hffff);
		xf(0, 16'h5631, 0, 0, 16'h0000);
		xf(0, 16'h5632, 0, 0, 16'ha5a5);
		kp = 1'b1;
		xf(0, 16'h5631, 0, 0, 16'h2468);
		xf(1, 16'h5630, 16'h0001, 1, 0);
		xf(1, 16'h2132, 16'h0001, 1, 0);
		xf(1, 16'h2134, 16'h0001, 1, 0);
	endtask : t_ident
	task automatic t_err;
		@(negedge clk);
		ev = 1'b1;
		ec = 16'h0bad;
		@(negedge clk);
		ev = 1'b0;
		xf(0, 16'h4545, 0, 0, 16'h0bad);
		xf(1, 16'h4545, 16'h1234, 0, 0);
		chk("error", le, 16'h00c0);
		xf(0, 16'h4545, 0, 0, 16'h00c0);
	endtask : t_err
	task automatic t_cmd;
		xf(0, 16'h2131, 0, 1, 0);
		xf(1, 16'h2131, 16'h1234, 1, 0);
		xf(1, 16'h2131, 16'h5555, 0, 0);
		xf(0, 16'h2132, 0, 0, 16'h0004);
		xf(1, 16'h2131, 16'h4444, 0, 0);
		chk("state", ms, 16'h0005);
		xf(1, 16'h2131, 16'h0111, 0, 0);
		chk("defaults", 16'(n_ld), 16'h0001);
		xf(1, 16'h2131, 16'h7777, 0, 0);
		chk("defaults", 16'(n_ld), 16'h0002);
		chk("code", 16'(n_lc), 16'h0001);
		xf(1, 16'h2131, 16'h0101, 0, 0);
		chk("state", ms, 16'h0003);
		fin(1, 0, 0, 0);
		chk("state", ms, 16'h0001);
		xf(1, 16'h2131, 16'h0101, 0, 0);
		fin(1, 0, 0, 1);
		chk("state", ms, 16'h0002);
		xf(1, 16'h2131, 16'h0101, 0, 0);
		fin(1, 0, 1, 1);
		chk("state", ms, 16'h0005);
		chk("restoring", {15'h0, nvr}, 16'h0000);
	endtask : t_cmd
	task automatic t_save;
		xf(1, 16'h2133, 16'h0001, 0, 0);
		chk("saving", {15'h0, nvs}, 16'h0001);
		xf(1, 16'h2133, 16'h0001, 1, 0);
		xf(0, 16'h2134, 0, 0, 16'h0001);
		fin(0, 1, 0, 0);
		xf(0, 16'h2134, 0, 0, 16'h0002);
		xf(1, 16'h2133, 16'h0000, 0, 0);
		chk("progress", sp, 16'h0000);
		xf(1, 16'h2133, 16'h0002, 1, 0);
		xf(0, 16'h2133, 0, 1, 0);
		xf(1, 16'h2133, 16'h0001, 0, 0);
		fin(0, 1, 1, 0);
		chk("progress", sp, 16'h0000);
	endtask : t_save
	task automatic t_tags;
		int tbl[5] = '{0, 935, 936, 1611, 1612};
		foreach (tbl[i]) begin
			@(negedge clk);
			tv = 1'b1;
			tg = tbl[i][10:0];
			@(negedge clk);
			tv = 1'b0;
			chk("mnem valid", {15'h0, mnv}, 16'h0001);
			chk("mnem", mno, tbl[i] < 1612 ? mn_of(tbl[i]) : 16'h0000);
			chk("mnem nak", {15'h0, mnk}, {15'h0, tbl[i] >= 1612});
		end
	endtask : t_tags
	task automatic t_link;
		logic got;
		int lat;
		spa_pkg::spa_rsp_t r;
		xf(1, mn_of(198), 16'h0007, 0, 0);
		chk("baud", bs, 16'h0007);
		xf(0, mn_of(198), 0, 0, 16'h0007);
		xf(1, 16'h3237, 16'h0042, 0, 0);
		xf(0, 16'h3237, 0, 0, 16'h0042);
		fm = spa_pkg::SPA_FMT_DEC;
		pt = 1'b0;
		xf(1, mn_of(198), 16'h0005, 1, 0);
		chk("baud", bs, 16'h0007);
		pt = 1'b1;
		xf(1, mn_of(198), 16'h0005, 0, 0);
		chk("baud", bs, 16'h0005);
		fm = spa_pkg::SPA_FMT_BOOL;
		xf(1, mn_of(100), 16'h0002, 1, 0);
		xf(1, mn_of(100), 16'h0001, 0, 0);
		fm = spa_pkg::SPA_FMT_WORD;
		xf(0, mn_of(100), 0, 0, 16'h0001);
		sup.xfer(0, 16'h4949, 0, fm, 1'b1, cl ^ 8'h01, got, lat, r);
		chk("unaddressed", {15'h0, got}, 16'h0000);
	endtask : t_link
	// leaving ascii mode silences the port, only a reset brings it back
	task automatic t_mode;
		logic got;
		int lat;
		spa_pkg::spa_rsp_t r;
		xf(1, mn_of(130), 16'h0002, 0, 0);
		chk("ascii", {15'h0, am}, 16'h0000);
		sup.xfer(0, 16'h4949, 0, fm, 1'b1, cl, got, lat, r);
		chk("port off", {15'h0, got}, 16'h0000);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("ascii", {15'h0, am}, 16'h0001);
		chk("state", ms, 16'h0003);
		chk("restoring", {15'h0, nvr}, 16'h0001);
		xf(0, 16'h4949, 0, 0, 16'h1234);
	endtask : t_mode
	initial begin
		{rst_n, kp, ev, rd, rok, cok, sd, sok, tv} = '0;
		{tg, ec, n_ld, n_lc, mismatches, n_compared} = '0;
		mv = 16'hffff;
		kv = 16'h2468;
		ov = 16'ha5a5;
		cl = 8'h12;
		st = 8'h03;
		fm = spa_pkg::SPA_FMT_WORD;
		pt = 1'b1;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_boot;
		t_ident;
		t_err;
		t_cmd;
		t_save;
		t_tags;
		t_link;
		t_mode;
		wrap_up;
	end
	// some 43 messages of 6 cycles each; far more than that means a hang
	initial begin
		#(40 * 20000);
		mismatches++;
		wrap_up;
	end
endmodule : spa_param_access_tb_top
